// ---- src/interp_if.sv ----
`timescale 1ns/100ps
interface interp_if;
  import interp_pkg::*;
  logic              msg_valid;
  logic              msg_ready;
  logic [DESC_W-1:0] msg_desc;
  logic [MASK_W-1:0] msg_mask;
  logic              pay_valid;
  logic              pay_ready;
  logic [GRF_W-1:0]  pay_data;
  logic              wb_valid;
  logic [BEAT_W-1:0] wb_index;
  logic [GRF_W-1:0]  wb_data;
  logic [REG_DW-1:0] wb_dw_en;
  logic              wb_last;

  modport unit
  (
    input  msg_valid, msg_desc, msg_mask, pay_valid, pay_data,
    output msg_ready, pay_ready, wb_valid, wb_index, wb_data, wb_dw_en, wb_last
  );
  modport thread
  (
    output msg_valid, msg_desc, msg_mask, pay_valid, pay_data,
    input  msg_ready, pay_ready, wb_valid, wb_index, wb_data, wb_dw_en, wb_last
  );
endinterface

// ---- src/interp_pkg.sv ----
package interp_pkg;
  // Descriptor field positions.
  localparam int DESC_W     = 20;
  localparam int HDR_BIT    = 19;
  localparam int SIMD_BIT   = 16;
  localparam int MODE_BIT   = 14;
  localparam int TYPE_LSB   = 12;
  localparam int GRP_BIT    = 11;
  localparam int YOFF_LSB   = 4;
  localparam int XOFF_LSB   = 0;
  localparam int SPEC_W     = 8;
  // Offsets are signed sixteenths of a pixel.
  localparam int OFF_W      = 4;
  localparam int FRAC_W     = 4;
  localparam int DWORD_W    = 32;
  localparam int REG_DW     = 8;
  localparam int GRF_W      = REG_DW * DWORD_W;
  localparam int MAX_SLOTS  = 16;
  localparam int SLOT_W     = 4;
  localparam int BYPASS     = 32;
  localparam int SAMPLES    = 8;
  localparam int SAMP_IDX_W = 3;
  localparam int BEAT_W     = 2;
  localparam int MASK_W     = 16;
  // Requester register map, byte addresses.
  localparam int          ADDR_W   = 12;
  localparam logic [11:0] DESC_OFS = 12'h000;
  localparam logic [11:0] MASK_OFS = 12'h004;
  localparam logic [11:0] CMD_OFS  = 12'h008;
  localparam logic [11:0] STAT_OFS = 12'h00c;
  localparam int          WIN_LSB  = 7;
  localparam logic [4:0]  PAY_WIN  = 5'h02;
  localparam logic [4:0]  RES_WIN  = 5'h04;
  localparam int          START_BIT = 0;
  localparam int          CLEAR_BIT = 1;

  typedef enum logic [1:0]
  {
    MSG_COMMON   = 2'h0,
    MSG_SAMPLE   = 2'h1,
    MSG_CENTROID = 2'h2,
    MSG_PER_SLOT = 2'h3
  } msg_type_t;

  // Index of the last payload register of a request.
  function automatic logic [BEAT_W-1:0] payload_last(input logic simd16, input msg_type_t t);
    if (t != MSG_PER_SLOT)
      return 2'h0;
    return simd16 ? 2'h3 : 2'h1;
  endfunction

  // Index of the last response register of a request.
  function automatic logic [BEAT_W-1:0] reply_last(input logic simd16);
    return simd16 ? 2'h3 : 2'h1;
  endfunction
endpackage

// ---- src/interp_thread.sv ----
`timescale 1ns/100ps
module interp_thread
  import interp_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  interp_if.thread                link,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               persp_sel_any,
  input  wire logic               linear_sel_any,
  input  wire logic               src_w_used
);
  typedef enum logic [1:0]
  {
    TS_IDLE = 2'b00,
    TS_MSG  = 2'b01,
    TS_PAY  = 2'b11,
    TS_WAIT = 2'b10
  } tstate_t;

  tstate_t                        state_q;
  logic [DESC_W-1:0]              desc_q;
  logic [MASK_W-1:0]              mask_q;
  logic [4*REG_DW-1:0][31:0]      pay_q;
  logic [4*REG_DW-1:0][31:0]      res_q;
  logic [BEAT_W-1:0]              beat_q;
  logic                           done_q;
  logic                           err_q;
  logic [31:0]                    prdata_q;
  logic                           wr;
  logic                           start;
  logic                           clear;
  logic                           bad;
  logic                           mapped;
  logic                           finish;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode. Every access completes with no wait state.
  assign mapped  = (paddr == DESC_OFS) || (paddr == MASK_OFS) || (paddr == CMD_OFS) ||
                   (paddr == STAT_OFS) || (paddr[ADDR_W-1:WIN_LSB] == PAY_WIN) ||
                   (paddr[ADDR_W-1:WIN_LSB] == RES_WIN);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_q;
  assign wr      = psel && penable && pwrite && mapped;
  assign start   = wr && (paddr == CMD_OFS) && pwdata[START_BIT] && (state_q == TS_IDLE);
  assign clear   = wr && (paddr == CMD_OFS) && pwdata[CLEAR_BIT];
  assign finish  = (state_q == TS_WAIT) && link.wb_valid && link.wb_last;
  // A request that could hang the unit is refused and flagged instead.
  assign bad     = (desc_q[MODE_BIT] && (persp_sel_any || src_w_used)) ||
                   (!desc_q[MODE_BIT] && linear_sel_any) ||
                   (!desc_q[SIMD_BIT] && desc_q[GRP_BIT]);

  // Header bit forced clear; this end stands for a pixel shader thread.
  assign link.msg_valid = (state_q == TS_MSG);
  assign link.msg_desc  = {1'b0, desc_q[HDR_BIT-1:0]};
  assign link.msg_mask  = mask_q;
  assign link.pay_valid = (state_q == TS_PAY);
  assign link.pay_data  = pay_q[beat_q*REG_DW +: REG_DW];

  // Read data is registered in the setup cycle and shown in the access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable)
    begin
      prdata_q <= 32'h0000_0000;
      if (paddr == DESC_OFS)
        prdata_q <= {12'h000, desc_q};
      else if (paddr == MASK_OFS)
        prdata_q <= {16'h0000, mask_q};
      else if (paddr == STAT_OFS)
        prdata_q <= {29'h0, err_q, done_q, state_q != TS_IDLE};
      else if (paddr[ADDR_W-1:WIN_LSB] == PAY_WIN)
        prdata_q <= pay_q[paddr[6:2]];
      else if (paddr[ADDR_W-1:WIN_LSB] == RES_WIN)
        prdata_q <= res_q[paddr[6:2]];
    end
  end

  // Software-written request fields and payload registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      desc_q <= '0;
      mask_q <= '0;
      pay_q  <= '0;
    end
    else if (wr && state_q == TS_IDLE)
    begin
      if (paddr == DESC_OFS)
        desc_q <= pwdata[DESC_W-1:0];
      if (paddr == MASK_OFS)
        mask_q <= pwdata[MASK_W-1:0];
      if (paddr[ADDR_W-1:WIN_LSB] == PAY_WIN)
        pay_q[paddr[6:2]] <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request sequencer.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= TS_IDLE;
      beat_q  <= 2'h0;
    end
    else
    begin
      unique case (state_q)
        TS_IDLE:
        begin
          if (start && !bad)
            state_q <= TS_MSG;
        end
        TS_MSG:
        begin
          beat_q <= 2'h0;
          if (link.msg_ready)
            state_q <= TS_PAY;
        end
        TS_PAY:
        begin
          if (link.pay_ready)
          begin
            if (beat_q == payload_last(desc_q[SIMD_BIT], msg_type_t'(desc_q[TYPE_LSB +: 2])))
              state_q <= TS_WAIT;
            else
              beat_q <= beat_q + 2'h1;
          end
        end
        TS_WAIT:
        begin
          if (finish)
            state_q <= TS_IDLE;
        end
      endcase
    end
  end

  // Status flags: a new event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end
    else
    begin
      done_q <= finish || (done_q && !clear);
      err_q  <= (start && bad) || (err_q && !clear);
    end
  end

  // Writeback leaves disabled dwords of the destination untouched.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      res_q <= '0;
    else if (state_q == TS_WAIT && link.wb_valid)
    begin
      for (int i = 0; i < REG_DW; i++)
        if (link.wb_dw_en[i])
          res_q[{link.wb_index, i[2:0]}] <= link.wb_data[i*DWORD_W +: DWORD_W];
    end
  end
endmodule

// ---- src/interp_unit.sv ----
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module interp_unit
  import interp_pkg::*;
#(
  parameter int POS_W = 16
)
(
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  interp_if.unit                                   link,
  input  wire logic [BYPASS-1:0][POS_W-1:0]        pos_x,
  input  wire logic [BYPASS-1:0][POS_W-1:0]        pos_y,
  input  wire logic [BYPASS-1:0][OFF_W-1:0]        cent_x,
  input  wire logic [BYPASS-1:0][OFF_W-1:0]        cent_y,
  input  wire logic [SAMPLES-1:0][OFF_W-1:0]       samp_x,
  input  wire logic [SAMPLES-1:0][OFF_W-1:0]       samp_y,
  output logic                                     eval_valid,
  output logic [SLOT_W-1:0]                        eval_slot,
  output logic                                     eval_linear,
  output logic signed [POS_W+FRAC_W:0]             eval_x,
  output logic signed [POS_W+FRAC_W:0]             eval_y,
  input  wire logic                                eval_ack,
  input  wire logic [DWORD_W-1:0]                  eval_b1,
  input  wire logic [DWORD_W-1:0]                  eval_b2
);
  localparam int EV_W = POS_W + FRAC_W + 1;
  if (POS_W < 1 || POS_W > 24)
    $error("interp_unit: POS_W out of range");
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_PAY   = 2'b01,
    ST_EVAL  = 2'b11,
    ST_REPLY = 2'b10
  } state_t;
  state_t                       state_q;
  logic                         simd16_q, linear_q, grp_q, fresh_q;
  msg_type_t                    type_q;
  logic [SPEC_W-1:0]            spec_q;
  logic [MASK_W-1:0]            mask_q;
  logic [BEAT_W-1:0]            beat_q, wb_index_q;
  logic [SLOT_W-1:0]            slot_q, last_slot;
  logic [MAX_SLOTS-1:0][OFF_W-1:0]   off_x_q, off_y_q;
  logic [MAX_SLOTS-1:0][DWORD_W-1:0] b1_q, b2_q;
  logic                         wb_valid_q, wb_last_q;
  logic [GRF_W-1:0]             wb_data_q;
  logic [REG_DW-1:0]            wb_dw_en_q;
  logic signed [EV_W-1:0]       eval_x_q, eval_y_q;
  logic                         take_msg, take_pay, advance, pay_y, pay_half;
  logic [SLOT_W:0]              bidx;
  logic [OFF_W-1:0]             ox, oy;
  // Pixel position in sixteenths, displaced by a signed sixteenth offset.
  function automatic logic signed [EV_W-1:0] place(input logic [POS_W-1:0] p,
                                                    input logic [OFF_W-1:0] o);
    return $signed({1'b0, p, {FRAC_W{1'b0}}}) + EV_W'($signed(o));
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Handshakes. A disabled slot is skipped without asking the evaluator.
  assign take_msg        = link.msg_valid && (state_q == ST_IDLE);
  assign take_pay        = link.pay_valid && (state_q == ST_PAY);
  assign link.msg_ready  = (state_q == ST_IDLE);
  assign link.pay_ready  = (state_q == ST_PAY);
  assign eval_valid      = (state_q == ST_EVAL) && fresh_q && mask_q[slot_q];
  assign advance         = (state_q == ST_EVAL) && (!mask_q[slot_q] || (eval_valid && eval_ack));
  assign last_slot       = simd16_q ? 4'hf : 4'h7;
  assign pay_y           = simd16_q ? beat_q[1] : beat_q[0];
  assign pay_half        = simd16_q & beat_q[0];
  assign eval_slot       = slot_q;
  assign eval_linear     = linear_q;
  assign eval_x          = eval_x_q;
  assign eval_y          = eval_y_q;
  assign link.wb_valid   = wb_valid_q;
  assign link.wb_index   = wb_index_q;
  assign link.wb_data    = wb_data_q;
  assign link.wb_dw_en   = wb_dw_en_q;
  assign link.wb_last    = wb_last_q;
  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: request, payload registers, per-slot evaluation, reply.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
      beat_q  <= 2'h0;
      slot_q  <= 4'h0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (take_msg)
          begin
            state_q <= ST_PAY;
            beat_q  <= 2'h0;
          end
        end
        ST_PAY:
        begin
          if (take_pay)
          begin
            if (beat_q == payload_last(simd16_q, type_q))
            begin
              state_q <= ST_EVAL;
              slot_q  <= 4'h0;
            end
            else
              beat_q <= beat_q + 2'h1;
          end
        end
        ST_EVAL:
        begin
          if (advance)
          begin
            slot_q <= slot_q + 4'h1;
            if (slot_q == last_slot)
            begin
              state_q <= ST_REPLY;
              beat_q  <= 2'h0;
            end
          end
        end
        ST_REPLY:
        begin
          if (beat_q == reply_last(simd16_q))
            state_q <= ST_IDLE;
          else
            beat_q <= beat_q + 2'h1;
        end
      endcase
    end
  end
  // Descriptor decode, latched once per request. The header bit is not looked at.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      simd16_q <= 1'b0;
      linear_q <= 1'b0;
      type_q   <= MSG_COMMON;
      grp_q    <= 1'b0;
      spec_q   <= 8'h00;
      mask_q   <= 16'h0000;
    end
    else if (take_msg)
    begin
      simd16_q <= link.msg_desc[SIMD_BIT];
      linear_q <= link.msg_desc[MODE_BIT];
      type_q   <= msg_type_t'(link.msg_desc[TYPE_LSB +: 2]);
      grp_q    <= link.msg_desc[GRP_BIT];
      spec_q   <= link.msg_desc[SPEC_W-1:0];
      mask_q   <= link.msg_mask;
    end
  end
  // Per-slot offsets; other request types drop their payload register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      off_x_q <= '0;
      off_y_q <= '0;
    end
    else if (take_pay && type_q == MSG_PER_SLOT)
    begin
      for (int i = 0; i < REG_DW; i++)
      begin
        if (pay_y)
          off_y_q[{pay_half, i[2:0]}] <= link.pay_data[i*DWORD_W +: OFF_W];
        else
          off_x_q[{pay_half, i[2:0]}] <= link.pay_data[i*DWORD_W +: OFF_W];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Offset source for the current slot. Eight-slot requests force the low group.
  always_comb
  begin
    bidx = {simd16_q & grp_q, slot_q};
    ox   = 4'h0;
    oy   = 4'h0;
    unique case (type_q)
      MSG_COMMON:
      begin
        ox = spec_q[XOFF_LSB +: OFF_W];
        oy = spec_q[YOFF_LSB +: OFF_W];
      end
      MSG_SAMPLE:
      begin
        ox = samp_x[spec_q[YOFF_LSB +: SAMP_IDX_W]];
        oy = samp_y[spec_q[YOFF_LSB +: SAMP_IDX_W]];
      end
      MSG_CENTROID:
      begin
        ox = cent_x[bidx];
        oy = cent_y[bidx];
      end
      MSG_PER_SLOT:
      begin
        ox = off_x_q[slot_q];
        oy = off_y_q[slot_q];
      end
    endcase
  end
  // Coordinates lag the slot by a cycle, so a slot is only offered once fresh.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      eval_x_q <= '0;
      eval_y_q <= '0;
      fresh_q  <= 1'b0;
    end
    else
    begin
      eval_x_q <= place(pos_x[bidx], ox);
      eval_y_q <= place(pos_y[bidx], oy);
      fresh_q  <= (state_q == ST_EVAL) && !advance;
    end
  end
  // Results from the evaluator; disabled slots keep whatever was there.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      b1_q <= '0;
      b2_q <= '0;
    end
    else if (eval_valid && eval_ack)
    begin
      b1_q[slot_q] <= eval_b1;
      b2_q[slot_q] <= eval_b2;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Reply registers: index bit 1 picks the slot half, bit 0 the component.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wb_valid_q <= 1'b0;
      wb_index_q <= 2'h0;
      wb_data_q  <= '0;
      wb_dw_en_q <= 8'h00;
      wb_last_q  <= 1'b0;
    end
    else
    begin
      wb_valid_q <= (state_q == ST_REPLY);
      wb_index_q <= beat_q;
      wb_last_q  <= (state_q == ST_REPLY) && (beat_q == reply_last(simd16_q));
      wb_dw_en_q <= mask_q[beat_q[1]*REG_DW +: REG_DW];
      for (int i = 0; i < REG_DW; i++)
        wb_data_q[i*DWORD_W +: DWORD_W] <= beat_q[0] ? b2_q[{beat_q[1], i[2:0]}]
                                                     : b1_q[{beat_q[1], i[2:0]}];
    end
  end
endmodule

// ---- tb/interp_link_asserts.sv ----
`timescale 1ns/100ps
module interp_link_asserts
  import interp_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              msg_valid,
  input wire logic              msg_ready,
  input wire logic [DESC_W-1:0] msg_desc,
  input wire logic [MASK_W-1:0] msg_mask,
  input wire logic              pay_valid,
  input wire logic              pay_ready,
  input wire logic              wb_valid,
  input wire logic [BEAT_W-1:0] wb_index,
  input wire logic [REG_DW-1:0] wb_dw_en,
  input wire logic              wb_last
);
  logic              simd_q;
  logic              pslot_q;
  logic [MASK_W-1:0] mask_q;
  logic [2:0]        beats_q;
  wire               take = msg_valid && msg_ready;

  // Fields of the request in flight, so the reply can be judged against them.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      simd_q  <= 1'b0;
      pslot_q <= 1'b0;
      mask_q  <= '0;
    end
    else if (take)
    begin
      simd_q  <= msg_desc[SIMD_BIT];
      pslot_q <= msg_desc[TYPE_LSB+:2] == MSG_PER_SLOT;
      mask_q  <= msg_mask;
    end

  // Payload beats since the request was taken.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      beats_q <= 3'h0;
    else if (take)
      beats_q <= 3'h0;
    else if (pay_valid && pay_ready)
      beats_q <= beats_q + 3'h1;

  ////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence reply8_s;
    wb_valid && wb_index == 2'h1 && wb_last;
  endsequence
  sequence reply16_s;
    wb_valid && wb_index == 2'h1 && !wb_last ##1 wb_valid && wb_index == 2'h2 && !wb_last
    ##1 wb_valid && wb_index == 2'h3 && wb_last;
  endsequence

  hdr_clear_a: assert property (msg_valid |-> !msg_desc[HDR_BIT])
    else $error("header bit set on a request");
  group_low_a: assert property (msg_valid && !msg_desc[SIMD_BIT] |-> !msg_desc[GRP_BIT])
    else $error("narrow request with high slot group");
  msg_hold_a: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_desc))
    else $error("request changed before it was taken");
  pay_start_a: assert property (take |=> pay_ready)
    else $error("payload not accepted after request");
  reply_narrow_a: assert property (wb_valid && wb_index == 2'h0 && !simd_q |=> reply8_s)
    else $error("narrow reply not two registers");
  reply_wide_a: assert property (wb_valid && wb_index == 2'h0 && simd_q |=> reply16_s)
    else $error("wide reply not four registers");
  dw_enable_a: assert property (wb_valid |->
    wb_dw_en == (wb_index[1] ? mask_q[15:8] : mask_q[7:0]))
    else $error("dword enables differ from mask");
  beat_count_a: assert property (wb_valid && wb_index == 2'h0 |->
    beats_q == (pslot_q ? (simd_q ? 3'h4 : 3'h2) : 3'h1))
    else $error("wrong payload length");
  idle_back_a: assert property (wb_valid && wb_last |-> msg_ready)
    else $error("unit not idle at last reply");
endmodule

// ---- tb/test_pixel_interpolator_messages.sv ----
`timescale 1ns/100ps
module test_pixel_interpolator_messages;
  import interp_pkg::*;
  logic                          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0]             paddr;
  logic [31:0]                   pwdata, prdata;
  logic                          persp_sel_any, linear_sel_any, src_w_used;
  logic [BYPASS-1:0][15:0]       pos_x, pos_y;
  logic [BYPASS-1:0][OFF_W-1:0]  cent_x, cent_y;
  logic [SAMPLES-1:0][OFF_W-1:0] samp_x, samp_y;
  logic                          eval_valid, eval_linear, eval_ack, want_n, lin_e;
  logic [SLOT_W-1:0]             eval_slot, slot_n;
  logic signed [20:0]            eval_x, eval_y;
  logic [DWORD_W-1:0]            eval_b1, eval_b2;
  int                            ox[16], oy[16];
  int                            grp, evals, msgs, err_total, samples_checked;

  interp_if link ();
  interp_thread u_interp_thread (.pclk(pclk), .presetn(presetn), .link(link), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .persp_sel_any(persp_sel_any),
    .linear_sel_any(linear_sel_any), .src_w_used(src_w_used));
  interp_unit #(.POS_W(16)) u_interp_unit (.pclk(pclk), .presetn(presetn), .link(link),
    .pos_x(pos_x), .pos_y(pos_y), .cent_x(cent_x), .cent_y(cent_y), .samp_x(samp_x),
    .samp_y(samp_y), .eval_valid(eval_valid), .eval_slot(eval_slot),
    .eval_linear(eval_linear), .eval_x(eval_x), .eval_y(eval_y), .eval_ack(eval_ack),
    .eval_b1(eval_b1), .eval_b2(eval_b2));
  interp_link_asserts u_chk (.pclk(pclk), .presetn(presetn), .msg_valid(link.msg_valid),
    .msg_ready(link.msg_ready), .msg_desc(link.msg_desc), .msg_mask(link.msg_mask),
    .pay_valid(link.pay_valid), .pay_ready(link.pay_ready), .wb_valid(link.wb_valid),
    .wb_index(link.wb_index), .wb_dw_en(link.wb_dw_en), .wb_last(link.wb_last));

  // The free-running bench clock.
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Watch at the falling edge, where outputs are settled; answer at the rising edge.
  always @(negedge pclk)
  begin
    want_n <= eval_valid === 1'b1 && eval_ack === 1'b0;
    slot_n <= eval_slot;
    if (link.msg_valid === 1'b1 && link.msg_ready === 1'b1)
      msgs++;
    if (eval_valid === 1'b1 && eval_ack === 1'b0)
    begin
      evals++;
      check(32'(eval_x), 32'(16 * pos_x[grp + eval_slot] + ox[eval_slot]));
      check(32'(eval_y), 32'(16 * pos_y[grp + eval_slot] + oy[eval_slot]));
      check(32'(eval_linear), 32'(lin_e));
    end
  end
  // One-cycle acknowledge keeps the answer tied to the slot just seen.
  always @(posedge pclk)
  begin
    eval_ack <= want_n && !eval_ack;
    eval_b1  <= 32'h3f80_0000 | 32'(slot_n);
    eval_b2  <= 32'h4000_0000 | 32'(slot_n);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // The leading edge wait keeps two transfers from touching psel in one step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  ////////////////////////////////
  // Issue one request, wait for done, then read back every enabled slot.
  task automatic run_req(input logic [19:0] desc, input logic [15:0] mask);
    logic [31:0] q;
    int          n;
    int          r;
    evals = 0;
    wr(DESC_OFS, 32'(desc));
    wr(MASK_OFS, 32'(mask));
    wr(CMD_OFS, 32'h2);
    wr(CMD_OFS, 32'h1);
    q = 32'h0;
    n = 0;
    while (q[1] !== 1'b1 && n < 200)
    begin
      rd(STAT_OFS, q);
      n++;
    end
    check({29'h0, q[2:0]}, 32'h2);
    check(32'(evals), 32'($countones(desc[16] ? mask : {8'h00, mask[7:0]})));
    for (int s = 0; s < 16; s++)
      if (mask[s] && (desc[16] || s < 8))
      begin
        r = s / 8 * 2;
        rd(12'(12'h200 + (r * 8 + s % 8) * 4), q);
        check(q, 32'h3f80_0000 | 32'(s));
        rd(12'(12'h200 + ((r + 1) * 8 + s % 8) * 4), q);
        check(q, 32'h4000_0000 | 32'(s));
      end
  endtask

  // Narrow common offset: Y -3, X +5; stale payload and high mask bits must not matter.
  task automatic t_common();
    for (int s = 0; s < 16; s++)
    begin
      ox[s] = 5;
      oy[s] = -3;
    end
    grp   = 0;
    lin_e = 1'b0;
    wr(12'h100, 32'hffff_ffff);
    run_req(20'h000d5, 16'hff81);
    $display("common offset done");
  endtask

  // Wide linear sample request, high group, index 5 with junk in the low nibble.
  task automatic t_sample();
    for (int s = 0; s < 16; s++)
    begin
      ox[s] = $signed(samp_x[5]);
      oy[s] = $signed(samp_y[5]);
    end
    grp            = 16;
    lin_e          = 1'b1;
    linear_sel_any <= 1'b1;
    run_req(20'h1585f, 16'h8001);
    linear_sel_any <= 1'b0;
    $display("sample offset done");
  endtask

  // Narrow centroid request; the specific byte is junk.
  task automatic t_centroid();
    for (int s = 0; s < 16; s++)
    begin
      ox[s] = $signed(cent_x[s]);
      oy[s] = $signed(cent_y[s]);
    end
    grp   = 0;
    lin_e = 1'b0;
    run_req(20'h020a7, 16'h000c);
    $display("centroid done");
  endtask

  // Per-slot offsets over the full signed range, junk in the upper 28 bits.
  task automatic t_per_slot(input logic wide);
    for (int k = 0; k < (wide ? 16 : 8); k++)
    begin
      ox[k] = k - 8;
      oy[k] = 7 - k;
      wr(12'(12'h100 + k * 4), 32'hfedc_ba90 | 32'(4'(k - 8)));
      wr(12'(12'h100 + (wide ? 64 : 32) + k * 4), 32'h1234_5670 | 32'(4'(7 - k)));
    end
    grp   = 0;
    lin_e = 1'b0;
    run_req(wide ? 20'h13033 : 20'h03033, wide ? 16'hffff : 16'h00ff);
    $display("per slot done");
  endtask

  // Mode clashes are refused with err and no request; an unmapped read errors.
  task automatic t_refuse();
    logic [31:0] q;
    logic        e;
    int          m;
    for (int i = 0; i < 3; i++)
    begin
      persp_sel_any  <= i == 0;
      src_w_used     <= i == 1;
      linear_sel_any <= i == 2;
      m = msgs;
      wr(DESC_OFS, i < 2 ? 32'h4000 : 32'h0);
      wr(CMD_OFS, 32'h2);
      wr(CMD_OFS, 32'h1);
      rd(STAT_OFS, q);
      check({31'h0, q[2]}, 32'h1);
      check(32'(msgs), 32'(m));
    end
    persp_sel_any  <= 1'b0;
    src_w_used     <= 1'b0;
    linear_sel_any <= 1'b0;
    apb(1'b0, 12'h040, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
    check(q, 32'h0);
    $display("refusals done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // A hang costs one mismatch and still reaches the verdict.
  initial
  begin
    repeat (30000) @(posedge pclk);
    err_total++;
    tally_and_finish();
  end

  // Main sequence.
  initial
  begin
    {presetn, psel, penable, pwrite, persp_sel_any, linear_sel_any, src_w_used} = '0;
    {paddr, pwdata, lin_e} = '0;
    {grp, evals, msgs, err_total, samples_checked} = '0;
    for (int i = 0; i < BYPASS; i++)
    begin
      pos_x[i]  = 16'(10 + 3 * i);
      pos_y[i]  = 16'(200 - i);
      cent_x[i] = 4'(i);
      cent_y[i] = 4'(15 - i);
    end
    for (int i = 0; i < SAMPLES; i++)
    begin
      samp_x[i] = 4'(i + 8);
      samp_y[i] = 4'(i);
    end
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_common();
    t_sample();
    t_centroid();
    t_per_slot(1'b0);
    t_per_slot(1'b1);
    t_refuse();
    tally_and_finish();
  end
endmodule
